// file: imcc_pkg.sv
// What this block does
// - primary idle keeps primary oscillator running; only the core clock halts
// - from primary run, idle enable plus power-down enters primary idle
// - peripherals stay clocked from primary oscillator while core is stopped
// - start-up status flag stays set on primary idle entry
// - wake from primary idle runs core on primary after core-start delay
// - start-up status flag stays set after primary idle wake
// - wake leaves idle enable and clock select unchanged
// - secondary idle stops core and clocks peripherals from secondary oscillator
// - from secondary run, idle enable plus power-down enters secondary idle
// - switching to secondary stops primary, clears start-up flag, sets running flag
// - wake from secondary idle keeps peripherals on secondary, core after delay
// - secondary oscillator keeps running after secondary idle wake
// - power-down for secondary idle ignored while secondary oscillator disabled
// - peripheral clocks withheld until enabled secondary oscillator has started
// - interrupt, reset or watchdog time-out leaves any idle mode
package imcc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [1:0] ADDR_CTRL = 2'h0; // idle_enable, system_clock_select
    localparam logic [1:0] ADDR_STATUS = 2'h1; // flags and mode
    localparam int CTRL_IDLE_BIT = 7;
    localparam int CTRL_SCS_LSB = 0;
    localparam int STAT_OSC_STARTUP_STATUS_BIT = 3;
    localparam int STAT_SRUN_BIT = 2;
    localparam int STAT_MODE_LSB = 0;
    // ----------------------------------------
    // clock select codes
    // ----------------------------------------
    localparam logic [1:0] SCS_PRIMARY = 2'h2;
    localparam logic [1:0] SCS_SECONDARY = 2'h1;
    localparam logic [1:0] SCS_CONFIG = 2'h0;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CORE_START_DELAY_PS = 100000; // fixed core-start delay
    localparam int CORE_START_CYCLES = (CORE_START_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ----------------------------------------
    // modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        IMCC_RUN,
        IMCC_PRIMARY_IDLE_MODE,
        IMCC_SECONDARY_IDLE_MODE,
        IMCC_WAKE
    } imcc_mode_t;
endpackage

// file: imcc_delay.sv
`timescale 1ns/10ps
// fixed core-start delay counter
module imcc_delay #(
    parameter int CYCLES = imcc_pkg::CORE_START_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    output logic done_o
);
    initial begin
        if (CYCLES < 1 || CYCLES > 65536) begin
            $error("imcc_delay: CYCLES out of range");
        end
    end
    logic [15:0] cnt_q;
    logic busy_q;
    // ----------------------------------------
    // counter
    // ----------------------------------------
    // load on start, count down, one-cycle done when zero reached
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                cnt_q <= 16'(CYCLES - 1);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (cnt_q == 16'h0000) begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end
endmodule // imcc_delay

// file: imcc_ctrl.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// idle mode clock control
module imcc_ctrl #(
    parameter int DELAY_CYCLES = imcc_pkg::CORE_START_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sleep_i, // power-down instruction executed
    input wire logic irq_i, // enabled interrupt flagged
    input wire logic wdt_i, // watchdog time-out
    input wire logic secondary_osc_enable_i,
    input wire logic secondary_osc_ready_i, // secondary oscillator oscillating
    input wire logic primary_osc_ready_i,
    output logic core_clk_en_o,
    output logic periph_clk_en_o,
    output logic periph_on_secondary_o,
    output logic primary_osc_on_o,
    output logic secondary_osc_on_o,
    output logic fetch_release_o,
    output logic [1:0] mode_o
);
    initial begin
        if (DELAY_CYCLES < 1 || DELAY_CYCLES > 65535) begin
            $error("imcc_ctrl: DELAY_CYCLES out of range");
        end
    end
    imcc_pkg::imcc_mode_t mode_q;
    logic idle_enable_q;
    logic [1:0] system_clock_select_q;
    logic osc_startup_status_q;
    logic secondary_clock_running_q;
    logic on_secondary_q; // core clock source is the secondary oscillator
    logic wake;
    logic want_sec;
    logic want_pri;
    logic delay_start;
    logic delay_done;
    // ----------------------------------------
    // entry and exit decode
    // ----------------------------------------
    assign wake = irq_i | wdt_i;
    assign want_sec = sleep_i && idle_enable_q && mode_q == imcc_pkg::IMCC_RUN
        && (system_clock_select_q == imcc_pkg::SCS_SECONDARY
        || (system_clock_select_q == imcc_pkg::SCS_CONFIG && on_secondary_q))
        && secondary_osc_enable_i;
    assign want_pri = sleep_i && idle_enable_q && mode_q == imcc_pkg::IMCC_RUN
        && (system_clock_select_q == imcc_pkg::SCS_PRIMARY
        || (system_clock_select_q == imcc_pkg::SCS_CONFIG && !on_secondary_q));
    assign delay_start = wake && (mode_q == imcc_pkg::IMCC_PRIMARY_IDLE_MODE
        || mode_q == imcc_pkg::IMCC_SECONDARY_IDLE_MODE);
    imcc_delay #(
        .CYCLES(DELAY_CYCLES)
    ) u_delay (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .start_i(delay_start),
        .done_o(delay_done)
    );
    // ----------------------------------------
    // mode machine
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mode_q <= imcc_pkg::IMCC_RUN;
        end else begin
            unique case (mode_q)
                imcc_pkg::IMCC_RUN: begin
                    if (want_sec) begin
                        mode_q <= imcc_pkg::IMCC_SECONDARY_IDLE_MODE;
                    end else if (want_pri) begin
                        mode_q <= imcc_pkg::IMCC_PRIMARY_IDLE_MODE;
                    end
                end
                imcc_pkg::IMCC_PRIMARY_IDLE_MODE, imcc_pkg::IMCC_SECONDARY_IDLE_MODE: begin
                    if (wake) begin
                        mode_q <= imcc_pkg::IMCC_WAKE;
                    end
                end
                imcc_pkg::IMCC_WAKE: begin
                    if (delay_done) begin
                        mode_q <= imcc_pkg::IMCC_RUN;
                    end
                end
            endcase
        end
    end
    // ----------------------------------------
    // clock source tracking
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            on_secondary_q <= 1'b0;
        end else if (want_sec) begin
            on_secondary_q <= 1'b1;
        end else if (want_pri) begin
            on_secondary_q <= 1'b0;
        end
    end
    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_startup_status_q <= 1'b0;
            secondary_clock_running_q <= 1'b0;
        end else if (want_sec) begin
            osc_startup_status_q <= 1'b0;
            secondary_clock_running_q <= 1'b1;
        end else if (!on_secondary_q) begin
            osc_startup_status_q <= primary_osc_ready_i | osc_startup_status_q;
            secondary_clock_running_q <= 1'b0;
        end
    end
    // ----------------------------------------
    // control register; wake never writes it
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            idle_enable_q <= 1'b0;
            system_clock_select_q <= imcc_pkg::SCS_CONFIG;
        end else if (wr_i && addr_i == imcc_pkg::ADDR_CTRL) begin
            idle_enable_q <= wdata_i[imcc_pkg::CTRL_IDLE_BIT];
            system_clock_select_q <= wdata_i[imcc_pkg::CTRL_SCS_LSB +: 2];
        end
    end
    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= 8'h00;
            if (rd_i && addr_i == imcc_pkg::ADDR_CTRL) begin
                rdata_o[imcc_pkg::CTRL_IDLE_BIT] <= idle_enable_q;
                rdata_o[imcc_pkg::CTRL_SCS_LSB +: 2] <= system_clock_select_q;
            end else if (rd_i && addr_i == imcc_pkg::ADDR_STATUS) begin
                rdata_o[imcc_pkg::STAT_OSC_STARTUP_STATUS_BIT] <= osc_startup_status_q;
                rdata_o[imcc_pkg::STAT_SRUN_BIT] <= secondary_clock_running_q;
                rdata_o[imcc_pkg::STAT_MODE_LSB +: 2] <= mode_q;
            end
        end
    end
    // ----------------------------------------
    // clock gating outputs
    // ----------------------------------------
    assign core_clk_en_o = mode_q == imcc_pkg::IMCC_RUN;
    assign fetch_release_o = delay_done;
    assign primary_osc_on_o = !on_secondary_q;
    assign secondary_osc_on_o = secondary_osc_enable_i;
    assign periph_on_secondary_o = on_secondary_q;
    assign periph_clk_en_o = !on_secondary_q || secondary_osc_ready_i;
    assign mode_o = mode_q;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_wake_idle;
        (mode_q == imcc_pkg::IMCC_PRIMARY_IDLE_MODE || mode_q == imcc_pkg::IMCC_SECONDARY_IDLE_MODE) && wake;
    endsequence
    property p_core_halt;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode_q != imcc_pkg::IMCC_RUN) |-> !core_clk_en_o;
    endproperty
    a_core_halt: assert property (p_core_halt) else $error("core clock on while idle");
    property p_pri_keeps_osc;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode_q == imcc_pkg::IMCC_PRIMARY_IDLE_MODE) |-> primary_osc_on_o && periph_clk_en_o;
    endproperty
    a_pri_keeps_osc: assert property (p_pri_keeps_osc) else $error("primary idle lost osc");
    property p_sec_ignored;
        @(posedge ref_clk_i) disable iff (rst_i)
        (sleep_i && !secondary_osc_enable_i && mode_q == imcc_pkg::IMCC_RUN
         && system_clock_select_q == imcc_pkg::SCS_SECONDARY)
        |=> mode_q == imcc_pkg::IMCC_RUN;
    endproperty
    a_sec_ignored: assert property (p_sec_ignored) else $error("entered with osc off");
    property p_sec_flags;
        @(posedge ref_clk_i) disable iff (rst_i)
        want_sec |=> !osc_startup_status_q && secondary_clock_running_q && !primary_osc_on_o;
    endproperty
    a_sec_flags: assert property (p_sec_flags) else $error("secondary switch flags wrong");
    property p_wake_delay;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_wake_idle |=> (!core_clk_en_o) [*1] ##[0:300] (mode_q == imcc_pkg::IMCC_RUN);
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("wake did not finish");
    property p_ctrl_kept;
        @(posedge ref_clk_i) disable iff (rst_i)
        s_wake_idle ##0 !wr_i |=> $stable(idle_enable_q) && $stable(system_clock_select_q);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept) else $error("wake changed control");
    property p_sec_periph;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode_q == imcc_pkg::IMCC_SECONDARY_IDLE_MODE && !secondary_osc_ready_i) |-> !periph_clk_en_o;
    endproperty
    a_sec_periph: assert property (p_sec_periph) else $error("periph clocked early");
    property p_sec_wake_stay;
        @(posedge ref_clk_i) disable iff (rst_i)
        (mode_q == imcc_pkg::IMCC_SECONDARY_IDLE_MODE && wake) |=> periph_on_secondary_o;
    endproperty
    a_sec_wake_stay: assert property (p_sec_wake_stay) else $error("left secondary");
    property p_release;
        @(posedge ref_clk_i) disable iff (rst_i)
        fetch_release_o |=> core_clk_en_o;
    endproperty
    a_release: assert property (p_release) else $error("fetch release without run");
endmodule // imcc_ctrl

// file: imcc_ctrl_tb.sv
`timescale 1ns/10ps
module imcc_ctrl_tb;
    // ----------------------------------------
    // stimulus and design
    // ----------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic irq_i = 1'b0;
    logic wdt_i = 1'b0;
    logic sec_en = 1'b0;
    logic sec_rdy = 1'b0;
    logic pri_rdy = 1'b1;
    logic [7:0] rdata_o;
    logic core_clk_en_o, periph_clk_en_o, periph_on_secondary_o;
    logic primary_osc_on_o, secondary_osc_on_o, fetch_release_o;
    logic [1:0] mode_o;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    localparam int DLY = 4;
    // clock at 40 MHz
    always #12.5 ref_clk_i = ~ref_clk_i;
    imcc_ctrl #(.DELAY_CYCLES(DLY)) imcc_ctrl_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sleep_i(sleep_i), .irq_i(irq_i),
        .wdt_i(wdt_i), .secondary_osc_enable_i(sec_en), .secondary_osc_ready_i(sec_rdy),
        .primary_osc_ready_i(pri_rdy), .core_clk_en_o(core_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .periph_on_secondary_o(periph_on_secondary_o),
        .primary_osc_on_o(primary_osc_on_o), .secondary_osc_on_o(secondary_osc_on_o),
        .fetch_release_o(fetch_release_o), .mode_o(mode_o));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    // power-down pulse, then mode one cycle later
    task automatic sleep(input logic [1:0] exp_mode);
        @(posedge ref_clk_i);
        sleep_i <= 1'b1;
        @(posedge ref_clk_i);
        sleep_i <= 1'b0;
        #1;
        chk(mode_o, exp_mode);
    endtask
    // wake pulse; fetch release counted from waking state
    task automatic wake(input bit by_wdt);
        int n;
        @(posedge ref_clk_i);
        if (by_wdt) irq_i <= 1'b0; else irq_i <= 1'b1;
        wdt_i <= by_wdt;
        @(posedge ref_clk_i);
        irq_i <= 1'b0;
        wdt_i <= 1'b0;
        #1;
        chk(mode_o, imcc_pkg::IMCC_WAKE);
        n = 0;
        while (fetch_release_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        chk(n, DLY);
        // mode returns to run on the clock after the release pulse
        @(posedge ref_clk_i);
        #1;
        chk(mode_o, imcc_pkg::IMCC_RUN);
        chk(core_clk_en_o, 1'b1);
    endtask
    // ----------------------------------------
    // hang guard
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(imcc_pkg::ADDR_CTRL, 8'h00);
        rd(2'h3, 8'h00);
        sleep(imcc_pkg::IMCC_RUN); // idle enable clear: ignored
        // primary idle straight from primary run
        wr(imcc_pkg::ADDR_CTRL, 8'h80);
        sleep(imcc_pkg::IMCC_PRIMARY_IDLE_MODE);
        chk(core_clk_en_o, 1'b0);
        chk({periph_clk_en_o, periph_on_secondary_o, primary_osc_on_o}, 8'h05);
        rd(imcc_pkg::ADDR_STATUS, 8'h09);
        wake(1'b0);
        rd(imcc_pkg::ADDR_STATUS, 8'h08);
        rd(imcc_pkg::ADDR_CTRL, 8'h80);
        // secondary oscillator disabled: entry refused
        wr(imcc_pkg::ADDR_CTRL, 8'h81);
        sleep(imcc_pkg::IMCC_RUN);
        chk(core_clk_en_o, 1'b1);
        // enabled but not yet oscillating
        @(posedge ref_clk_i);
        sec_en <= 1'b1;
        sleep(imcc_pkg::IMCC_SECONDARY_IDLE_MODE);
        chk(periph_clk_en_o, 1'b0);
        @(posedge ref_clk_i);
        sec_rdy <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        chk({periph_clk_en_o, periph_on_secondary_o, primary_osc_on_o}, 8'h06);
        chk(core_clk_en_o, 1'b0);
        rd(imcc_pkg::ADDR_STATUS, 8'h06);
        wake(1'b1);
        chk({periph_on_secondary_o, secondary_osc_on_o}, 8'h03);
        rd(imcc_pkg::ADDR_CTRL, 8'h81);
        rd(imcc_pkg::ADDR_STATUS, 8'h04);
        // secondary run straight into secondary idle
        sleep(imcc_pkg::IMCC_SECONDARY_IDLE_MODE);
        wake(1'b0);
        // back to primary idle from secondary run
        wr(imcc_pkg::ADDR_CTRL, 8'h82);
        sleep(imcc_pkg::IMCC_PRIMARY_IDLE_MODE);
        chk({periph_on_secondary_o, primary_osc_on_o}, 8'h01);
        wake(1'b1);
        rd(imcc_pkg::ADDR_CTRL, 8'h82);
        conclude();
    end
endmodule // imcc_ctrl_tb
